// ### hdl/wrf_pkg.sv
// package: constants and carrier types for the windowed register file
// What this block does
// - 32-bit registers, 8 globals, 24 per window
// - eight windows numbered 0 through 7
// - save decrements pointer, restore/return increments it
// - pointer wraps modulo window count
// - outs equal ins after pointer decrement
// - ins equal outs after pointer increment
// - globals shared, locals private per window
// - save checks and flags window overflow
// - restore checks and flags window underflow
// - two source operands out, result written back
// - mask bit per window raises over/underflow
// - global zero reads zero, writes ignored
// - unimplemented mask bits read zero, ignored
package wrf_pkg;
  localparam int DATA_W      = 32;
  localparam int NUM_GLOBALS = 8;
  localparam int WIN_REGS    = 24;
  localparam int NUM_WINDOWS = 8;
  localparam int PTR_W       = 5;
  localparam int ADDR_W      = 5;
  localparam int MASK_W      = 32;
  localparam logic [1:0] GRP_GLOBAL = 2'h0;
  localparam logic [1:0] GRP_OUT    = 2'h1;
  localparam logic [1:0] GRP_LOCAL  = 2'h2;
  localparam logic [1:0] GRP_IN     = 2'h3;
  localparam logic [PTR_W-1:0]  PTR_RESET  = 5'h00;
  localparam logic [MASK_W-1:0] MASK_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    WOP_NONE    = 3'h0,
    WOP_SAVE    = 3'h1,
    WOP_RESTORE = 3'h2,
    WOP_TRAP_RET = 3'h3,
    WOP_SET_PTR = 3'h4
  } win_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] src1_addr;
    logic [ADDR_W-1:0] src2_addr;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
  } rf_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] src1_data;
    logic [DATA_W-1:0] src2_data;
  } rf_rsp_t;
endpackage

// ### hdl/wrf_addr_map.sv
// module: maps a window-relative address to a physical register index
`timescale 1ns/1ps
module wrf_addr_map
  import wrf_pkg::*;
#(
  parameter int NWIN  = NUM_WINDOWS,
  parameter int IDX_W = 8
) (
  input  wire logic [PTR_W-1:0]  window_pointer_field,
  input  wire logic [ADDR_W-1:0] addr,
  output logic      [IDX_W-1:0]  phys_idx
);
  localparam int SLOT = 16;
  logic [PTR_W-1:0] win;
  int unsigned      idx;

  always_comb begin
    win = window_pointer_field;
    idx = 0;
    case (addr[4:3])
      GRP_GLOBAL: idx = addr[2:0];
      // outs of window w are the ins of window w-1
      GRP_OUT: begin
        win = (window_pointer_field == '0) ?
              PTR_W'(NWIN - 1) : window_pointer_field - 5'h01;
        idx = NUM_GLOBALS + win * SLOT + addr[2:0];
      end
      GRP_LOCAL: idx = NUM_GLOBALS + window_pointer_field * SLOT
                       + 8 + addr[2:0];
      GRP_IN: idx = NUM_GLOBALS + window_pointer_field * SLOT
                    + addr[2:0];
      default: idx = 0;
    endcase
  end
  assign phys_idx = IDX_W'(idx);
endmodule

// ### hdl/windowed_register_file.sv
// module: overlapping-window integer register file with window control
`timescale 1ns/1ps
module windowed_register_file
  import wrf_pkg::*;
#(
  parameter int NWIN = NUM_WINDOWS
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire rf_req_t           req,
  output rf_rsp_t                rsp,
  input  wire win_op_t           win_op,
  input  wire logic [PTR_W-1:0]  ptr_wr_data,
  input  wire logic              mask_wr_en,
  input  wire logic [MASK_W-1:0] mask_wr_data,
  output logic [PTR_W-1:0]       window_pointer_field,
  output logic [MASK_W-1:0]      invalid_window_mask,
  output logic                   win_overflow,
  output logic                   win_underflow
);
  // each window owns 16 private slots (ins + locals); outs alias neighbour
  localparam int PHYS  = NUM_GLOBALS + NWIN * 16;
  localparam int IDX_W = $clog2(PHYS);

  initial begin
    if (NWIN < 2 || NWIN > 32)
      $error("window count must be 2..32");
  end

  logic [DATA_W-1:0] regs_ff [PHYS];
  logic [DATA_W-1:0] nxt_regs [PHYS];
  logic [PTR_W-1:0]  ptr_ff, nxt_ptr;
  logic [MASK_W-1:0] mask_ff, nxt_mask;
  logic              ovf_ff, nxt_ovf, unf_ff, nxt_unf;
  rf_rsp_t           rsp_ff, nxt_rsp;
  logic [IDX_W-1:0]  idx_s1, idx_s2, idx_wr;
  logic [PTR_W-1:0]  ptr_dec, ptr_inc;
  logic [MASK_W-1:0] impl_mask;

  wrf_addr_map #(.NWIN(NWIN), .IDX_W(IDX_W)) u_map_s1 (
    .window_pointer_field (ptr_ff),
    .addr                 (req.src1_addr),
    .phys_idx             (idx_s1)
  );
  wrf_addr_map #(.NWIN(NWIN), .IDX_W(IDX_W)) u_map_s2 (
    .window_pointer_field (ptr_ff),
    .addr                 (req.src2_addr),
    .phys_idx             (idx_s2)
  );
  wrf_addr_map #(.NWIN(NWIN), .IDX_W(IDX_W)) u_map_wr (
    .window_pointer_field (ptr_ff),
    .addr                 (req.wr_addr),
    .phys_idx             (idx_wr)
  );

  always_comb begin
    impl_mask = '0;
    for (int w = 0; w < NWIN; w++) begin
      impl_mask[w] = 1'b1;
    end
    ptr_dec = (ptr_ff == '0) ? PTR_W'(NWIN - 1) : ptr_ff - 5'h01;
    ptr_inc = (ptr_ff == PTR_W'(NWIN - 1)) ? '0 : ptr_ff + 5'h01;
  end

  // window pointer, mask and trap conditions
  always_comb begin
    nxt_ptr  = ptr_ff;
    nxt_mask = mask_ff;
    nxt_ovf  = 1'b0;
    nxt_unf  = 1'b0;
    if (mask_wr_en) begin
      nxt_mask = mask_wr_data & impl_mask;
    end
    case (win_op)
      WOP_SAVE: begin
        if (mask_ff[ptr_dec]) begin
          nxt_ovf = 1'b1;
        end else begin
          nxt_ptr = ptr_dec;
        end
      end
      WOP_RESTORE, WOP_TRAP_RET: begin
        if (mask_ff[ptr_inc]) begin
          nxt_unf = 1'b1;
        end else begin
          nxt_ptr = ptr_inc;
        end
      end
      WOP_SET_PTR: begin
        if ({1'b0, ptr_wr_data} < (PTR_W+1)'(NWIN)) begin
          nxt_ptr = ptr_wr_data;
        end
      end
      default: nxt_ptr = ptr_ff;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff  <= PTR_RESET;
      mask_ff <= MASK_RESET;
      ovf_ff  <= 1'b0;
      unf_ff  <= 1'b0;
    end else begin
      ptr_ff  <= nxt_ptr;
      mask_ff <= nxt_mask;
      ovf_ff  <= nxt_ovf;
      unf_ff  <= nxt_unf;
    end
  end

  // storage write and registered operand read
  always_comb begin
    nxt_regs = regs_ff;
    if (req.wr_en && req.wr_addr != '0) begin
      nxt_regs[idx_wr] = req.wr_data;
    end
    nxt_rsp.src1_data = (req.src1_addr == '0) ? '0 : regs_ff[idx_s1];
    nxt_rsp.src2_data = (req.src2_addr == '0) ? '0 : regs_ff[idx_s2];
  end

  genvar g;
  generate
    for (g = 0; g < PHYS; g++) begin : g_reg
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          regs_ff[g] <= '0;
        end else begin
          regs_ff[g] <= nxt_regs[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign rsp                  = rsp_ff;
  assign window_pointer_field = ptr_ff;
  assign invalid_window_mask  = mask_ff;
  assign win_overflow         = ovf_ff;
  assign win_underflow        = unf_ff;
endmodule

// ### verif/wrf_checker.sv
// checker: operand and window control properties
`timescale 1ns/1ps
module wrf_checker
  import wrf_pkg::*;
#(
  parameter int NWIN = NUM_WINDOWS
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire rf_req_t           req,
  input wire rf_rsp_t           rsp,
  input wire win_op_t           win_op,
  input wire logic [PTR_W-1:0]  window_pointer_field,
  input wire logic [MASK_W-1:0] invalid_window_mask,
  input wire logic              win_overflow,
  input wire logic              win_underflow
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [PTR_W-1:0] dn;
  logic [PTR_W-1:0] up;
  logic             sv;
  logic             rs;
  assign dn = PTR_W'((int'(window_pointer_field) + NWIN - 1) % NWIN);
  assign up = PTR_W'((int'(window_pointer_field) + 1) % NWIN);
  assign sv = win_op == WOP_SAVE;
  assign rs = win_op inside {WOP_RESTORE, WOP_TRAP_RET};
  chk_save_step: assert property (
    sv && !invalid_window_mask[dn] |=> window_pointer_field == $past(dn))
    else $error("save step");
  chk_restore_step: assert property (
    rs && !invalid_window_mask[up] |=> window_pointer_field == $past(up))
    else $error("restore step");
  chk_save_refused: assert property (
    sv && invalid_window_mask[dn] |=> win_overflow && $stable(dn))
    else $error("overflow");
  chk_restore_refused: assert property (
    rs && invalid_window_mask[up] |=> win_underflow && !win_overflow)
    else $error("underflow");
  chk_flag_cause: assert property (
    win_op == WOP_NONE |=> !win_overflow && !win_underflow)
    else $error("stray flag");
  chk_ptr_hold: assert property (
    win_op == WOP_NONE |=> $stable(window_pointer_field))
    else $error("pointer moved");
  chk_mask_high: assert property (
    (invalid_window_mask >> NWIN) == '0)
    else $error("mask high bits");
  chk_zero_src: assert property (
    req.src2_addr == 5'h00 |=> rsp.src2_data == 32'h0000_0000)
    else $error("zero source");
endmodule
bind windowed_register_file wrf_checker #(.NWIN(NWIN)) wrf_checker_inst (
  .sys_clk, .rst_n, .req, .rsp, .win_op, .window_pointer_field,
  .invalid_window_mask, .win_overflow, .win_underflow);

// ### verif/core_model.sv
// partner: integer core issuing operands and window ops
`timescale 1ns/1ps
module core_model
  import wrf_pkg::*;
(
  input  wire logic         sys_clk,
  output rf_req_t           req,
  output win_op_t           win_op,
  output logic [PTR_W-1:0]  ptr_wr_data,
  output logic              mask_wr_en,
  output logic [MASK_W-1:0] mask_wr_data
);
  initial begin
    req = '0;
    win_op = WOP_NONE;
    {ptr_wr_data, mask_wr_en, mask_wr_data} = '0;
  end
  task automatic issue(input rf_req_t r, input win_op_t o,
                       input logic [37:0] c);
    @(posedge sys_clk);
    #1;
    req = r;
    win_op = o;
    {ptr_wr_data, mask_wr_en, mask_wr_data} = c;
  endtask
endmodule

// ### verif/tb_top.sv
// testbench: random operand and window traffic against a reference
`timescale 1ns/1ps
module tb_top
  import wrf_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  rf_req_t req;
  rf_rsp_t rsp;
  win_op_t win_op;
  logic [PTR_W-1:0] ptr_wr_data, window_pointer_field;
  logic mask_wr_en, win_overflow, win_underflow;
  logic [MASK_W-1:0] mask_wr_data, invalid_window_mask;
  logic [31:0] mem [0:135];
  logic [65:0] notes [$];
  logic [7:0] mask_m = '0;
  int num_errors = 0, tests_run = 0, cyc = 0, ptr = 0;
  int seed = 32'h3a39f2d1;
  windowed_register_file windowed_register_file_inst (.sys_clk, .rst_n,
    .req, .rsp, .win_op, .ptr_wr_data, .mask_wr_en, .mask_wr_data,
    .window_pointer_field, .invalid_window_mask, .win_overflow,
    .win_underflow);
  core_model core_model_inst (.sys_clk, .req, .win_op, .ptr_wr_data,
    .mask_wr_en, .mask_wr_data);
  always #2.5 sys_clk = ~sys_clk;
  function automatic int phys(int w, int a);
    return a < 8 ? a : a < 16 ? ((w + 7) % 8) * 16 + a :
           a < 24 ? w * 16 + a : w * 16 + a - 16;
  endfunction
  function automatic logic [31:0] rd(logic [4:0] a);
    return a == 5'h00 ? '0 : mem[phys(ptr, a)];
  endfunction
  task automatic step();
    logic [31:0] v;
    rf_req_t r;
    win_op_t o;
    logic [65:0] e;
    int n;
    v = $random(seed);
    r = {v[4:0], v[9:5], v[10], v[15:11], $random(seed)};
    o = v[18:16] > 3'h4 ? WOP_NONE : win_op_t'(v[18:16]);
    e = {2'b00, rd(r.src1_addr), rd(r.src2_addr)};
    if (r.wr_en && r.wr_addr != 5'h00) mem[phys(ptr, r.wr_addr)] = r.wr_data;
    n = o == WOP_SAVE ? (ptr + 7) % 8 : (ptr + 1) % 8;
    if (o inside {WOP_SAVE, WOP_RESTORE, WOP_TRAP_RET}) begin
      if (mask_m[n]) e[65:64] = o == WOP_SAVE ? 2'b10 : 2'b01;
      else ptr = n;
    end
    if (o == WOP_SET_PTR && v[23:19] < 5'h08) ptr = v[23:19];
    if (v[26:24] == 3'h7) mask_m = 8'h01 << v[29:27];
    core_model_inst.issue(r, o, {v[23:19], v[26:24] == 3'h7,
                          24'hffffff, 8'h01 << v[29:27]});
    notes.push_back(e);
  endtask
  task automatic check_out(input logic [65:0] e);
    tests_run++;
    if ({win_overflow, win_underflow, rsp} !== e) begin
      num_errors++;
      $display("[FAIL] %0t out %h exp %h", $time, rsp, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (notes.size() > 0) begin
      #2;
      check_out(notes.pop_front());
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    for (int i = 0; i < 136; i++) mem[i] = '0;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3000) step();
    repeat (3) @(posedge sys_clk);
    complete_run();
  end
endmodule
